// >>> src/dpcrm_top.sv
// What this block does
// - Counting relay latches at target until cleared
// - Over upper limit trips; recover below minus deadband
// - Under lower limit trips; recover above plus deadband
// - Recovery needs deadband margin, default one
// - Count updates after divider pulses, default one
// - Each divider completion adds multiplier
// - Point position only affects display; max 9999
// - Per-relay polarity make or break
// - Steady or half-second pulse; pulse keeps count
// - Auto clear timer clears count and relay
// - Per-relay clear pin enable, prompt clear
// - Per-relay hold enable keeps trip held
// - Relay 2 role only if relay 1 counts
// - Cascade counts relay 1 target hits
// - Monitoring waits for power-up hold-off
// - Fault must persist trip delay first
// - Fault flags shown unless messages disabled
// - Counts and divider progress saved and resumed
// - Full speed or debounced input filter
// - Count on closure or opening edge
// - Counting continues whatever is shown
// - Loop maps relay 1 value to 4/0-20 mA
// - Hold release restarts hold-off
// - Rate relay 1 forces relay 2 same rate
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "dpcrm_cfg.svh"
module dpcrm_top import dpcrm_pkg::*; #(
	parameter int unsigned TICK_CYC = `DPC_TICK_MS * 1000 * `DPC_CLK_MHZ,
	parameter int unsigned GATE_CYC = `DPC_GATE_MS * 1000 * `DPC_CLK_MHZ,
	parameter int unsigned FAST_CYC =
		(`DPC_CLK_MHZ * 1000000 + 2 * `DPC_FAST_HZ - 1) / (2 * `DPC_FAST_HZ),
	parameter int unsigned SLOW_CYC =
		(`DPC_CLK_MHZ * 1000000 + 2 * `DPC_SLOW_HZ - 1) / (2 * `DPC_SLOW_HZ)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Field pins
	input wire logic contact_closed,
	input wire logic clear_pin,
	input wire logic power_fail,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Outputs
	output logic relay1,
	output logic relay2,
	output logic [15:0] loop_ua
);
	localparam logic [15:0] PULSE_TICKS = 16'(`DPC_PULSE_MS / `DPC_TICK_MS);

	// Clamp to the largest showable value
	function automatic logic [15:0] clamp(input logic [31:0] v);
		return (v > {16'h0000, `DPC_MAXVAL}) ? `DPC_MAXVAL : v[15:0];
	endfunction : clamp

	// Saturating add
	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
		return clamp({16'h0000, a} + {16'h0000, b});
	endfunction : sat_add

	// Rate in the unit of the selected function
	function automatic logic [15:0] rate_of(input dpcrm_func_e k, input logic [15:0] hz);
		case (k)
			FN_REV: return clamp({16'h0000, hz} * `DPC_RPM_MUL);
			FN_HOURLY: return clamp({16'h0000, hz} * `DPC_PPH_MUL);
			default: return clamp({16'h0000, hz});
		endcase
	endfunction : rate_of

	// Global settings
	logic [15:0] ctrl, holdoff_t, trip_t, loop_zero, loop_span;
	// Per-channel settings
	logic [15:0] ch_cfg [2];
	logic [15:0] setp [2];
	logic [15:0] upper [2];
	logic [15:0] lower [2];
	logic [15:0] dband [2];
	logic [15:0] divr [2];
	logic [15:0] mult [2];
	logic [15:0] aclr [2];
	// Per-channel state
	logic [15:0] count [2];
	logic [15:0] divp [2];
	logic [15:0] val [2];
	logic [1:0] hit, hit_q, hit_ev, is_rate, tripped, trip_hi, trip_lo, next_relay;
	logic [5:0] flags;
	// Shared state
	logic cfg_rst, rate1, cascade2, pulse_ev, clr_rise, hold_fall, tick, monitor_on;
	logic filt, filt_q, clr_q, pf_q, restore_ok;
	logic [31:0] filt_cnt, tick_cnt, gate_cnt;
	logic [15:0] gate_pulses, rate_hz, ho_cnt, disp, mem_wdata, mem_rdata;
	logic [15:0] next_disp, next_loop;
	dpcrm_func_e kind [2];
	dpcrm_mem_e mstate;
	logic [2:0] midx;

	// Factory restore acts like reset on settings only
	assign cfg_rst = !reset_n || (reg_wr && reg_addr == `DPC_A_CMD &&
		reg_wdata[`DPC_C_CMD_DEF]);

	// Mode decode; relay 2 is free only while relay 1 counts
	assign kind[0] = dpcrm_func_e'(ctrl[1:0]);
	assign rate1 = kind[0] != FN_COUNT;
	assign cascade2 = !rate1 && ctrl[4:2] == 3'h1;
	assign is_rate[0] = rate1;
	assign is_rate[1] = rate1 || (ctrl[4:2] >= 3'h2 && ctrl[4:2] <= 3'h4);
	assign kind[1] = rate1 ? kind[0] : dpcrm_func_e'(2'(ctrl[4:2] - 3'h1));

	// Global settings write; decimal point bits only feed the display
	always_ff @(posedge clk) begin
		if (cfg_rst) begin
			ctrl <= `DPC_RST_CTRL;
			holdoff_t <= `DPC_RST_ZERO;
			trip_t <= `DPC_RST_ZERO;
			loop_zero <= `DPC_RST_ZERO;
			loop_span <= `DPC_RST_SPAN;
		end else if (reg_wr) begin
			case (reg_addr)
				`DPC_A_CTRL: ctrl <= reg_wdata;
				`DPC_A_HOLDOFF: holdoff_t <= reg_wdata;
				`DPC_A_TRIP: trip_t <= reg_wdata;
				`DPC_A_ZERO: loop_zero <= reg_wdata;
				`DPC_A_SPAN: loop_span <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Input filter: a level must stand the filter time to be taken
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			filt <= 1'b0;
			filt_cnt <= 32'h0000_0000;
		end else if (contact_closed == filt) begin
			filt_cnt <= 32'h0000_0000;
		end else if (filt_cnt >= (ctrl[`DPC_C_SLOW] ? SLOW_CYC : FAST_CYC) - 1) begin
			filt <= contact_closed;
			filt_cnt <= 32'h0000_0000;
		end else begin
			filt_cnt <= filt_cnt + 32'h0000_0001;
		end
	end

	// Edge history of the pins
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			filt_q <= 1'b0;
			clr_q <= 1'b0;
			pf_q <= 1'b0;
			hit_q <= 2'b00;
		end else begin
			filt_q <= filt;
			clr_q <= clear_pin;
			pf_q <= power_fail;
			hit_q <= hit;
		end
	end

	assign pulse_ev = ctrl[`DPC_C_EDGE] ? (filt_q && !filt) : (!filt_q && filt);
	assign clr_rise = clear_pin && !clr_q;
	assign hold_fall = !clear_pin && clr_q;
	assign hit_ev = hit & ~hit_q;

	// Tenth-second tick for all timers
	always_ff @(posedge clk) begin
		if (!reset_n || tick_cnt >= TICK_CYC - 1) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end
	assign tick = tick_cnt >= TICK_CYC - 1;

	// One-second gate gives pulses per second
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			gate_cnt <= 32'h0000_0000;
			gate_pulses <= 16'h0000;
			rate_hz <= 16'h0000;
		end else if (gate_cnt >= GATE_CYC - 1) begin
			gate_cnt <= 32'h0000_0000;
			gate_pulses <= 16'h0000;
			rate_hz <= gate_pulses;
		end else begin
			gate_cnt <= gate_cnt + 32'h0000_0001;
			if (pulse_ev) begin
				gate_pulses <= sat_add(gate_pulses, `DPC_RST_ONE);
			end
		end
	end

	// Hold-off after power-up and after each hold release
	always_ff @(posedge clk) begin
		if (!reset_n || (hold_fall &&
			(ch_cfg[0][`DPC_K_HOLDEN] || ch_cfg[1][`DPC_K_HOLDEN]))) begin
			ho_cnt <= 16'h0000;
		end else if (tick && ho_cnt < holdoff_t) begin
			ho_cnt <= ho_cnt + 16'h0001;
		end
	end
	assign monitor_on = ho_cnt >= holdoff_t;

	// Retention sequencer: restore after reset, save on power fail
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mstate <= MS_RESTORE;
			midx <= 3'h0;
			restore_ok <= 1'b0;
		end else begin
			case (mstate)
				MS_RESTORE: begin
					midx <= midx + 3'h1;
					if (midx == `DPC_M_SIG + 3'h1) begin
						restore_ok <= ctrl[`DPC_C_RETAIN] && mem_rdata == `DPC_SIG;
					end
					if (midx == `DPC_M_LAST + 3'h1) begin
						mstate <= MS_IDLE;
					end
				end
				MS_IDLE: begin
					midx <= 3'h0;
					if (power_fail && !pf_q && ctrl[`DPC_C_RETAIN]) begin
						mstate <= MS_SAVE;
					end
				end
				MS_SAVE: begin
					midx <= midx + 3'h1;
					if (midx == `DPC_M_LAST) begin
						mstate <= MS_IDLE;
					end
				end
				default: mstate <= MS_IDLE;
			endcase
		end
	end

	// Word written at each save step
	always_comb begin
		case (midx)
			`DPC_M_SIG: mem_wdata = `DPC_SIG;
			`DPC_M_CNT0: mem_wdata = count[0];
			`DPC_M_CNT0 + 3'h1: mem_wdata = divp[0];
			`DPC_M_CNT0 + `DPC_M_STRIDE: mem_wdata = count[1];
			default: mem_wdata = divp[1];
		endcase
	end

	dpcrm_keep_mem u_keep (
		.clk(clk),
		.we(mstate == MS_SAVE),
		.waddr(midx),
		.wdata(mem_wdata),
		.raddr(midx),
		.rdata(mem_rdata)
	);

	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic sel, inc_ev, clr_ev, ac_done, pulse_on, over, under, hold_act, recov;
		logic ld_cnt, ld_div;
		logic [15:0] pulse_cnt, ac_cnt, td_cnt, div_lim;
		assign sel = reg_addr[7:4] == ((c == 0) ? `DPC_CH1 : `DPC_CH2);

		// Channel settings write
		always_ff @(posedge clk) begin
			if (cfg_rst) begin
				ch_cfg[c] <= `DPC_RST_CHCFG;
				setp[c] <= `DPC_RST_ONE;
				upper[c] <= `DPC_RST_ZERO;
				lower[c] <= `DPC_RST_ZERO;
				dband[c] <= `DPC_RST_ONE;
				divr[c] <= `DPC_RST_ONE;
				mult[c] <= `DPC_RST_ONE;
				aclr[c] <= `DPC_RST_ZERO;
			end else if (reg_wr && sel) begin
				case (reg_addr[3:0])
					`DPC_F_CFG: ch_cfg[c] <= reg_wdata;
					`DPC_F_SETP: setp[c] <= reg_wdata;
					`DPC_F_UPPER: upper[c] <= reg_wdata;
					`DPC_F_LOWER: lower[c] <= reg_wdata;
					`DPC_F_DBAND: dband[c] <= reg_wdata;
					`DPC_F_DIV: divr[c] <= reg_wdata;
					`DPC_F_MULT: mult[c] <= reg_wdata;
					`DPC_F_ACLR: aclr[c] <= reg_wdata;
					default: ;
				endcase
			end
		end

		// Event sources; cascade takes relay 1 target hits
		assign inc_ev = !is_rate[c] && ((c == 1 && cascade2) ? hit_ev[0] : pulse_ev);
		assign clr_ev = (clr_rise && ch_cfg[c][`DPC_K_CLREN] && !is_rate[c]) ||
			ac_done ||
			(reg_wr && reg_addr == `DPC_A_CMD && reg_wdata[c]);
		assign div_lim = (divr[c] == 16'h0000) ? 16'h0000 : divr[c] - 16'h0001;
		assign ld_cnt = mstate == MS_RESTORE && restore_ok &&
			midx == `DPC_M_CNT0 + 3'(c) * `DPC_M_STRIDE + 3'h1;
		assign ld_div = mstate == MS_RESTORE && restore_ok &&
			midx == `DPC_M_CNT0 + 3'(c) * `DPC_M_STRIDE + 3'h2;

		// Main count with divider and multiplier, runs whatever is shown
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				count[c] <= 16'h0000;
				divp[c] <= 16'h0000;
			end else if (ld_cnt || ld_div) begin
				if (ld_cnt) begin
					count[c] <= mem_rdata;
				end else begin
					divp[c] <= mem_rdata;
				end
			end else if (clr_ev) begin
				count[c] <= 16'h0000;
				divp[c] <= 16'h0000;
			end else if (inc_ev) begin
				if (divp[c] >= div_lim) begin
					divp[c] <= 16'h0000;
					count[c] <= sat_add(count[c], mult[c]);
				end else begin
					divp[c] <= divp[c] + 16'h0001;
				end
			end
		end

		// Target latch holds until a clear
		always_ff @(posedge clk) begin
			if (!reset_n || clr_ev || is_rate[c]) begin
				hit[c] <= 1'b0;
			end else if (count[c] >= setp[c]) begin
				hit[c] <= 1'b1;
			end
		end

		// Half-second output pulse; it never clears the count
		always_ff @(posedge clk) begin
			if (!reset_n || clr_ev) begin
				pulse_cnt <= 16'h0000;
			end else if (hit_ev[c]) begin
				pulse_cnt <= PULSE_TICKS;
			end else if (tick && pulse_on) begin
				pulse_cnt <= pulse_cnt - 16'h0001;
			end
		end
		assign pulse_on = pulse_cnt != 16'h0000;

		// Auto clear after the programmed time from the target
		always_ff @(posedge clk) begin
			if (!reset_n || !hit[c]) begin
				ac_cnt <= 16'h0000;
				ac_done <= 1'b0;
			end else begin
				if (tick && ac_cnt < aclr[c]) begin
					ac_cnt <= ac_cnt + 16'h0001;
				end
				ac_done <= aclr[c] != 16'h0000 && ac_cnt >= aclr[c];
			end
		end

		// Window comparison with deadband
		assign val[c] = rate_of(kind[c], rate_hz);
		assign over = ch_cfg[c][`DPC_K_UPEN] && val[c] > upper[c];
		assign under = ch_cfg[c][`DPC_K_LOEN] && val[c] < lower[c];
		assign hold_act = clear_pin && ch_cfg[c][`DPC_K_HOLDEN];
		assign recov = (!trip_hi[c] || {1'b0, val[c]} + {1'b0, dband[c]} < {1'b0, upper[c]}) &&
			(!trip_lo[c] || {1'b0, val[c]} > {1'b0, lower[c]} + {1'b0, dband[c]});

		// Trip state: delayed fault entry, held recovery
		always_ff @(posedge clk) begin
			if (!reset_n || !is_rate[c]) begin
				tripped[c] <= 1'b0;
				trip_hi[c] <= 1'b0;
				trip_lo[c] <= 1'b0;
				td_cnt <= 16'h0000;
			end else if (!tripped[c]) begin
				if (monitor_on && (over || under)) begin
					if (td_cnt >= trip_t) begin
						tripped[c] <= 1'b1;
						trip_hi[c] <= over;
						trip_lo[c] <= under;
					end else if (tick) begin
						td_cnt <= td_cnt + 16'h0001;
					end
				end else begin
					td_cnt <= 16'h0000;
				end
			end else if (!hold_act && recov) begin
				tripped[c] <= 1'b0;
				trip_hi[c] <= 1'b0;
				trip_lo[c] <= 1'b0;
				td_cnt <= 16'h0000;
			end
		end

		// Relay drive with polarity
		assign next_relay[c] = ch_cfg[c][`DPC_K_POL] ^ (is_rate[c] ? !tripped[c] :
			(ch_cfg[c][`DPC_K_TIMED] ? pulse_on : hit[c]));
		assign flags[3 * c +: 3] = {tripped[c] && hold_act, trip_lo[c], trip_hi[c]} &
			{3{ctrl[`DPC_C_MSG]}};
	end

	// Relay outputs straight from flops
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			relay1 <= 1'b0;
			relay2 <= 1'b0;
		end else begin
			relay1 <= next_relay[0];
			relay2 <= next_relay[1];
		end
	end

	// Loop value: zero maps to low level, zero plus span to 20 mA
	always_comb begin
		logic [15:0] lo, d;
		lo = ctrl[`DPC_C_LOOP0] ? 16'h0000 : `DPC_UA_LO;
		d = 16'h0000;
		if (is_rate[0] ? val[0] <= loop_zero : count[0] <= loop_zero) begin
			next_loop = lo;
		end else begin
			d = (is_rate[0] ? val[0] : count[0]) - loop_zero;
			if (d >= loop_span) begin
				next_loop = `DPC_UA_HI;
			end else begin
				next_loop = lo + 16'(({16'h0000, d} * {16'h0000, `DPC_UA_HI - lo}) /
					{16'h0000, loop_span});
			end
		end
	end

	// Shown value; remaining counts go negative past the target
	always_comb begin
		case (dpcrm_disp_e'(ctrl[12:10]))
			DS_C1_LEFT: next_disp = setp[0] - count[0];
			DS_RATE: next_disp = is_rate[1] ? val[1] : val[0];
			DS_C2_UP: next_disp = count[1];
			DS_C2_LEFT: next_disp = setp[1] - count[1];
			default: next_disp = count[0];
		endcase
	end

	// Display and loop registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			disp <= 16'h0000;
			loop_ua <= `DPC_UA_LO;
		end else begin
			disp <= next_disp;
			loop_ua <= next_loop;
		end
	end

	// Register read, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!reset_n || !reg_rd) begin
			reg_rdata <= 16'h0000;
		end else if (reg_addr[7:4] == `DPC_CH1 || reg_addr[7:4] == `DPC_CH2) begin
			case (reg_addr[3:0])
				`DPC_F_CFG: reg_rdata <= ch_cfg[reg_addr[5]];
				`DPC_F_SETP: reg_rdata <= setp[reg_addr[5]];
				`DPC_F_UPPER: reg_rdata <= upper[reg_addr[5]];
				`DPC_F_LOWER: reg_rdata <= lower[reg_addr[5]];
				`DPC_F_DBAND: reg_rdata <= dband[reg_addr[5]];
				`DPC_F_DIV: reg_rdata <= divr[reg_addr[5]];
				`DPC_F_MULT: reg_rdata <= mult[reg_addr[5]];
				`DPC_F_ACLR: reg_rdata <= aclr[reg_addr[5]];
				`DPC_F_COUNT: reg_rdata <= count[reg_addr[5]];
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			case (reg_addr)
				`DPC_A_CTRL: reg_rdata <= ctrl;
				`DPC_A_HOLDOFF: reg_rdata <= holdoff_t;
				`DPC_A_TRIP: reg_rdata <= trip_t;
				`DPC_A_ZERO: reg_rdata <= loop_zero;
				`DPC_A_SPAN: reg_rdata <= loop_span;
				`DPC_A_STAT: reg_rdata <= {7'h00, relay2, relay1, monitor_on, flags};
				`DPC_A_DISP: reg_rdata <= disp;
				`DPC_A_RATE: reg_rdata <= rate_hz;
				`DPC_A_LOOP: reg_rdata <= loop_ua;
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule : dpcrm_top

// >>> inc/dpcrm_cfg.svh
`ifndef DPCRM_CFG_SVH
`define DPCRM_CFG_SVH

// Clock and time bases
`define DPC_CLK_MHZ 250
`define DPC_TICK_MS 100
`define DPC_GATE_MS 1000
`define DPC_PULSE_MS 500
`define DPC_FAST_HZ 8000
`define DPC_SLOW_HZ 30

// Value limits and loop levels in microamps
`define DPC_MAXVAL 16'h270F
`define DPC_UA_LO 16'h0FA0
`define DPC_UA_HI 16'h4E20
`define DPC_RPM_MUL 32'h0000_003C
`define DPC_PPH_MUL 32'h0000_0E10

// Retention store layout; signature value is arbitrary
`define DPC_SIG 16'hA5C3
`define DPC_M_SIG 3'h0
`define DPC_M_CNT0 3'h1
`define DPC_M_STRIDE 3'h2
`define DPC_M_LAST 3'h4

// Global register addresses
`define DPC_A_CTRL 8'h00
`define DPC_A_HOLDOFF 8'h01
`define DPC_A_TRIP 8'h02
`define DPC_A_ZERO 8'h03
`define DPC_A_SPAN 8'h04
`define DPC_A_CMD 8'h05
`define DPC_A_STAT 8'h06
`define DPC_A_DISP 8'h07
`define DPC_A_RATE 8'h08
`define DPC_A_LOOP 8'h09

// Channel blocks and field offsets
`define DPC_CH1 4'h1
`define DPC_CH2 4'h2
`define DPC_F_CFG 4'h0
`define DPC_F_SETP 4'h1
`define DPC_F_UPPER 4'h2
`define DPC_F_LOWER 4'h3
`define DPC_F_DBAND 4'h4
`define DPC_F_DIV 4'h5
`define DPC_F_MULT 4'h6
`define DPC_F_ACLR 4'h7
`define DPC_F_COUNT 4'h8

// Control register fields
`define DPC_C_EDGE 5
`define DPC_C_SLOW 6
`define DPC_C_RETAIN 7
`define DPC_C_LOOP0 8
`define DPC_C_MSG 9
`define DPC_C_CMD_DEF 2

// Channel configuration fields
`define DPC_K_POL 0
`define DPC_K_TIMED 1
`define DPC_K_CLREN 2
`define DPC_K_HOLDEN 3
`define DPC_K_UPEN 4
`define DPC_K_LOEN 5

// Reset values
`define DPC_RST_CTRL 16'h0280
`define DPC_RST_CHCFG 16'h000C
`define DPC_RST_ONE 16'h0001
`define DPC_RST_ZERO 16'h0000
`define DPC_RST_SPAN 16'h03E8

`endif

// >>> inc/dpcrm_pkg.sv
package dpcrm_pkg;
	// Function of a relay channel
	typedef enum logic [1:0] {FN_COUNT, FN_REV, FN_HZ, FN_HOURLY} dpcrm_func_e;
	// Retention sequencer
	typedef enum logic [1:0] {MS_RESTORE, MS_IDLE, MS_SAVE} dpcrm_mem_e;
	// Shown value source
	typedef enum logic [2:0] {DS_C1_UP, DS_C1_LEFT, DS_RATE, DS_C2_UP, DS_C2_LEFT} dpcrm_disp_e;
endpackage : dpcrm_pkg

// >>> src/dpcrm_keep_mem.sv
`timescale 1ns/1ps
`include "dpcrm_cfg.svh"
module dpcrm_keep_mem (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [15:0] wdata,
	// Read port
	input wire logic [2:0] raddr,
	output logic [15:0] rdata
);
	// Storage is not reset: it stands for the non-volatile save area
	logic [15:0] mem [`DPC_M_LAST + 3'h1];

	// Write side
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read, one cycle late
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule : dpcrm_keep_mem

// >>> tb/dpcrm_checker.sv
`timescale 1ns/1ps
module dpcrm_checker #(
	parameter int unsigned TICK_CYC = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Field pins
	input wire logic contact_closed,
	input wire logic clear_pin,
	input wire logic power_fail,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Outputs
	input wire logic relay1,
	input wire logic relay2,
	input wire logic [15:0] loop_ua
);
	// Shadows of control, relay 1 config and relay 1 auto clear time
	logic [15:0] ctrl_q;
	logic [15:0] cfg1_q;
	logic [15:0] aclr_q;
	// Cycles relay 1 has stood high
	int unsigned hi_len;
	// Relay 1 counts rather than measures rate
	logic count_mode;
	assign count_mode = ctrl_q[1:0] == 2'h0;
	// Shadows follow writes; the defaults command puts them back
	always_ff @(posedge clk) begin
		if (!reset_n || (reg_wr && reg_addr == 8'h05 && reg_wdata[2])) begin
			ctrl_q <= 16'h0280;
			cfg1_q <= 16'h000C;
			aclr_q <= 16'h0000;
		end else if (reg_wr && reg_addr == 8'h00) begin
			ctrl_q <= reg_wdata;
		end else if (reg_wr && reg_addr == 8'h10) begin
			cfg1_q <= reg_wdata;
		end else if (reg_wr && reg_addr == 8'h17) begin
			aclr_q <= reg_wdata;
		end
	end
	// Length of the current high phase, for the timed pulse
	always_ff @(posedge clk) begin
		if (!reset_n || !relay1) begin
			hi_len <= 0;
		end else begin
			hi_len <= hi_len + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// A read strobe at a given address
	sequence s_rd(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence
	// Clear pin edge on a counting relay that honours it
	sequence s_clr;
		count_mode && cfg1_q[2] && $rose(clear_pin);
	endsequence
	// Timed relay pulse ending
	sequence s_timed_end;
		count_mode && cfg1_q[1] && !cfg1_q[0] && $fell(relay1);
	endsequence
	// Reset must hold both relays off and the loop at its floor
	reset_quiet_a: assert property (disable iff (1'b0)
		!reset_n |=> !relay1 && !relay2 && loop_ua == 16'h0FA0)
		else $error("outputs not quiet after reset");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its read cycle");
	unmapped_zero_a: assert property (s_rd(8'hFF) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	ctrl_readback_a: assert property (s_rd(8'h00) |=> reg_rdata == ctrl_q)
		else $error("control readback wrong");
	loop_ceiling_a: assert property (loop_ua <= 16'h4E20)
		else $error("loop above full scale");
	loop_floor_a: assert property (!ctrl_q[8] && !$past(ctrl_q[8]) |-> loop_ua >= 16'h0FA0)
		else $error("loop below floor in offset range");
	clear_drop_a: assert property (s_clr |-> ##[1:4] relay1 == cfg1_q[0])
		else $error("clear pin did not reset relay 1");
	relay_latch_a: assert property (count_mode && !cfg1_q[1] && !cfg1_q[0] && aclr_q == 0
		&& relay1 && !clear_pin && !$past(clear_pin) && !reg_wr && !$past(reg_wr) |=> relay1)
		else $error("latched relay 1 dropped");
	pulse_len_a: assert property (s_timed_end |->
		hi_len >= 4 * TICK_CYC && hi_len <= 5 * TICK_CYC + 3)
		else $error("timed relay pulse length wrong");
endmodule : dpcrm_checker

bind dpcrm_top dpcrm_checker #(.TICK_CYC(TICK_CYC)) i_chk (.clk(clk), .reset_n(reset_n),
	.contact_closed(contact_closed), .clear_pin(clear_pin), .power_fail(power_fail),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .relay1(relay1), .relay2(relay2), .loop_ua(loop_ua));

// >>> tb/dpcrm_contact_model.sv
`timescale 1ns/1ps
// Pulse switch on the input; rests open between bursts
module dpcrm_contact_model (
	// Clock
	input wire logic clk,
	// Contact level, high while shorted
	output logic contact_closed
);
	initial contact_closed = 1'b0;
	// Closes and opens n times; each phase lasts half cycles
	task automatic send(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			contact_closed <= 1'b1;
			repeat (half) @(posedge clk);
			contact_closed <= 1'b0;
			repeat (half - 1) @(posedge clk);
		end
	endtask : send
endmodule : dpcrm_contact_model

// >>> tb/dpcrm_bench.sv
`timescale 1ns/1ps
module dpcrm_bench;
	// Stimulus and observed signals
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic contact_closed;
	logic clear_pin = 1'b0;
	logic power_fail = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic relay1;
	logic relay2;
	logic [15:0] loop_ua;
	int num_errors = 0;
	int n_compared = 0;
	always #2 clk = ~clk;
	// Short time bases keep the run brief: tick 10, gate 100 cycles
	dpcrm_top #(.TICK_CYC(10), .GATE_CYC(100), .FAST_CYC(2), .SLOW_CYC(8)) i_dut (
		.clk(clk), .reset_n(reset_n), .contact_closed(contact_closed),
		.clear_pin(clear_pin), .power_fail(power_fail), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.relay1(relay1), .relay2(relay2), .loop_ua(loop_ua));
	dpcrm_contact_model i_sw (.clk(clk), .contact_closed(contact_closed));
	// Verdict and end of run
	task wrap_up;
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word
	task chk_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	// One write cycle
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read strobe, then take the data in the one cycle it stands
	task chk_reg(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk_word($sformatf("reg %h", a), exp, reg_rdata);
	endtask : chk_reg
	// Pulses, then room for filter and count pipeline
	task pulses(input int n, input int half);
		i_sw.send(n, half);
		repeat (8) @(posedge clk);
		#1;
	endtask : pulses
	// Clear pin pulse held long enough to be seen
	task clr_pin;
		@(posedge clk);
		clear_pin <= 1'b1;
		repeat (6) @(posedge clk);
		clear_pin <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : clr_pin
	// Bounded wait for relay 1; a run-out ends the run
	task wait_rel(input logic exp, input int lim);
		int k;
		k = 0;
		while (relay1 !== exp && k < lim) begin
			@(posedge clk);
			#1 k++;
		end
		chk_bit("relay1", exp, relay1);
		if (relay1 !== exp) wrap_up;
	endtask : wait_rel
	// An ignored write to an unmapped place, then reset values
	task t_defaults;
		logic [7:0] da [8] = '{8'h00, 8'h10, 8'h20, 8'h14, 8'h15, 8'h16, 8'h04, 8'h01};
		logic [15:0] dv [8] = '{16'h0280, 16'h000C, 16'h000C, 16'h0001, 16'h0001,
			16'h0001, 16'h03E8, 16'h0000};
		wr(8'hFF, 16'h1234);
		chk_reg(8'hFF, 16'h0000);
		for (int i = 0; i < 8; i++) chk_reg(da[i], dv[i]);
	endtask : t_defaults
	// Divide by 3, multiply by 7, partial divider progress kept
	task t_scale;
		wr(8'h11, 16'h270F);
		wr(8'h15, 16'h0003);
		wr(8'h16, 16'h0007);
		pulses(7, 6);
		chk_reg(8'h18, 16'h000E);
		pulses(2, 6);
		chk_reg(8'h18, 16'h0015);
	endtask : t_scale
	// Debounced input drops fast pulses and keeps slow ones
	task t_debounce;
		wr(8'h00, 16'h02C0);
		wr(8'h15, 16'h0001);
		wr(8'h16, 16'h0001);
		wr(8'h05, 16'h0001);
		pulses(3, 4);
		chk_reg(8'h18, 16'h0000);
		pulses(3, 12);
		chk_reg(8'h18, 16'h0003);
		wr(8'h00, 16'h0280);
	endtask : t_debounce
	// Latch at target, clear pin honoured, then ignored
	task t_target;
		wr(8'h05, 16'h0001);
		wr(8'h11, 16'h0005);
		pulses(4, 6);
		chk_bit("relay1 below", 1'b0, relay1);
		pulses(1, 6);
		wait_rel(1'b1, 20);
		clr_pin;
		chk_bit("relay1 cleared", 1'b0, relay1);
		chk_reg(8'h18, 16'h0000);
		wr(8'h10, 16'h0008);
		pulses(5, 6);
		wait_rel(1'b1, 20);
		clr_pin;
		chk_bit("relay1 kept", 1'b1, relay1);
		wr(8'h10, 16'h000C);
		clr_pin;
	endtask : t_target
	// Timed output pulse leaves the count alone
	task t_timed;
		wr(8'h10, 16'h000E);
		pulses(5, 6);
		wait_rel(1'b1, 20);
		wait_rel(1'b0, 80);
		chk_reg(8'h18, 16'h0005);
		clr_pin;
		wr(8'h10, 16'h000C);
	endtask : t_timed
	// Auto clear three ticks after the target
	task t_autoclr;
		wr(8'h17, 16'h0003);
		pulses(5, 6);
		wait_rel(1'b1, 20);
		wait_rel(1'b0, 60);
		chk_reg(8'h18, 16'h0000);
		wr(8'h17, 16'h0000);
	endtask : t_autoclr
	// Counter 2 counts target hits: divide 2, multiply 3
	task t_cascade;
		wr(8'h00, 16'h0284);
		wr(8'h05, 16'h0002);
		wr(8'h20, 16'h0008);
		wr(8'h25, 16'h0002);
		wr(8'h26, 16'h0003);
		wr(8'h11, 16'h0002);
		pulses(2, 6);
		wait_rel(1'b1, 20);
		chk_reg(8'h28, 16'h0000);
		clr_pin;
		pulses(2, 6);
		wait_rel(1'b1, 20);
		chk_reg(8'h28, 16'h0003);
		clr_pin;
	endtask : t_cascade
	// Count 500 of span 1000 in both loop ranges
	task t_loop;
		wr(8'h00, 16'h0280);
		wr(8'h11, 16'h270F);
		wr(8'h16, 16'h00FA);
		pulses(2, 6);
		chk_word("loop 4-20", 16'h2EE0, loop_ua);
		wr(8'h00, 16'h0380);
		repeat (4) @(posedge clk);
		#1 chk_word("loop 0-20", 16'h2710, loop_ua);
	endtask : t_loop
	// Counts saved at power fail come back after a mid-run reset
	task t_retain;
		@(posedge clk);
		power_fail <= 1'b1;
		repeat (8) @(posedge clk);
		reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		power_fail <= 1'b0;
		repeat (8) @(posedge clk);
		chk_reg(8'h18, 16'h01F4);
	endtask : t_retain
	// Rate above upper limit trips, recovers once pulses stop
	task t_rate;
		wr(8'h00, 16'h0382);
		wr(8'h12, 16'h0004);
		wr(8'h10, 16'h001C);
		wait_rel(1'b1, 50);
		pulses(40, 6);
		chk_bit("relay1 trip", 1'b0, relay1);
		chk_bit("relay2 rate", 1'b1, relay2);
		wait_rel(1'b1, 400);
	endtask : t_rate
	// Reset held six cycles, settle, then each scenario in turn
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		t_defaults;
		t_scale;
		t_debounce;
		t_target;
		t_timed;
		t_autoclr;
		t_cascade;
		t_loop;
		t_retain;
		t_rate;
		wrap_up;
	end
endmodule : dpcrm_bench
